/* File: core/spcs_port.sv */
// Serial port control/status register with its shifters.
// Assumes CPU strobes are on clk_sys and rxdIn is an asynchronous pin.
// Contract
// - The two mode bits select modes 0 to 3 as a binary number.
// - Mode 0 is a synchronous shifter at one sixth the oscillator.
// - Mode 1 is 8-bit asynchronous at a variable rate.
// - Mode 2 is 9-bit asynchronous at oscillator/16 or /32.
// - Mode 3 equals mode 2 except the rate is variable.
// - Modes 2,3 with filter on: ninth bit 0 sets no receive flag.
// - Mode 1 with filter on: bad stop bit sets no receive flag.
// - Reception only while receive enable is set by software.
// - Modes 2,3 transmit the stored ninth bit.
// - Modes 2,3 load the received ninth bit on acceptance.
// - Mode 1 with filter off loads the stop bit as ninth bit.
// - Mode 0 reception leaves the received ninth bit alone.
// - Transmit flag set after bit 8 in mode 0, at stop otherwise.
// - Hardware never clears the transmit flag; software does.
// - Receive flag set after bit 8 in mode 0, mid-stop otherwise.
// - Hardware never clears the receive flag; software does.
// - Any write to the data buffer starts a transmission.
// - Mode 0 receives on flag clear and enable; others on start.
// - Mode 1 frame: start 0, eight data LSB first, stop 1.
// - Receive is buffered; a frame ending while unread is lost.
`timescale 1ns/1ps
`include "spcs_cfg.svh"
module spcs_port (
    input wire logic clk_sys,
    input wire logic nrst,
    input spcs_pkg::spcs_cpu_req_t cpuReq,
    input wire logic rateTick,
    input wire logic smodDouble,
    input wire logic rxdIn,
    output logic [7:0] regRdData,
    output spcs_pkg::spcs_pins_t pinsOut
);
    import spcs_pkg::*;

    spcs_state_t q, d;
    spcs_mode_t mode;
    logic tick16;
    logic ctlWr;
    logic dataWr;
    logic nine;
    logic rxAccept;
    logic rxStopSample;
    logic [7:0] rxFrameData;
    logic rxFrameNinth;

    // Data bits per frame, counted without start and stop
    function automatic logic [3:0] frameBits(input spcs_mode_t m);
        frameBits = (m == SPCS_MODE_UART8 || m == SPCS_MODE_SHIFT) ?
            4'h8 : 4'h9;
    endfunction : frameBits

    // Nine-bit modes carry the programmable ninth bit
    function automatic logic nineBit(input spcs_mode_t m);
        nineBit = (m == SPCS_MODE_UART9_FIX || m == SPCS_MODE_UART9_VAR);
    endfunction : nineBit

    // Mode straight from the two select bits
    assign mode = spcs_mode_t'({q.ctl[`SPCS_MODE_HI],
        q.ctl[`SPCS_MODE_LO]});
    assign nine = nineBit(mode);
    assign ctlWr = cpuReq.wrEn && (cpuReq.sel == `SPCS_SEL_CTL);
    assign dataWr = cpuReq.wrEn && (cpuReq.sel == `SPCS_SEL_DATA);

    // Oversample tick: fixed in mode 2, outside source in modes 1 and 3
    spcs_rate_gen #(.DIV_W(2)) u_rate (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .mode(mode),
        .smodDouble(smodDouble),
        .rateTick(rateTick),
        .tick16(tick16)
    );

    // Next state of the whole port
    always_comb begin
        d = q;
        rxAccept = 1'b0;
        rxStopSample = 1'b0;
        // 9-bit frames hold data low; 8-bit frames shifted one place up
        rxFrameData = nine ? q.rxShift[7:0] : q.rxShift[8:1];
        rxFrameNinth = nine ? q.rxShift[8] : q.rxLine;

        // Pin filter: stage 0 feeds stage 1 only
        d.rxSync = {q.rxSync[1:0], rxdIn};
        if (q.rxSync[1] == q.rxSync[2]) begin
            d.rxLine = q.rxSync[2];
        end

        // Software writes first, so hardware sets below win
        if (ctlWr) begin
            d.ctl = cpuReq.wrData;
        end
        if (cpuReq.rdEn) begin
            d.rdData = (cpuReq.sel == `SPCS_SEL_DATA) ? q.rxBuf : q.ctl;
        end

        // Transmit engine
        case (q.txState)
            SPCS_TX_START: begin
                if (tick16) begin
                    d.txTicks = q.txTicks + 4'h1;
                    if (q.txTicks == `SPCS_LAST_TICK) begin
                        d.txState = SPCS_TX_SHIFT;
                        d.pins.txd = q.txShift[0];
                    end
                end
            end
            SPCS_TX_SHIFT: begin
                if (mode == SPCS_MODE_SHIFT) begin
                    // Shift clock low then high, data moves on the fall
                    d.txTicks = (q.txTicks == `SPCS_M0_LAST) ?
                        4'h0 : q.txTicks + 4'h1;
                    d.pins.txd = (d.txTicks >= `SPCS_M0_HALF);
                    if (q.txTicks == `SPCS_M0_LAST) begin
                        d.txShift = {1'b1, q.txShift[9:1]};
                        d.txBits = q.txBits + 4'h1;
                        d.pins.rxdOut = q.txShift[1];
                        if (q.txBits == frameBits(mode) - 4'h1) begin
                            d.txState = SPCS_TX_IDLE;
                            d.ctl[`SPCS_TI] = 1'b1;
                            d.pins.txd = 1'b1;
                            d.pins.rxdOut = 1'b1;
                            d.pins.rxdOe = 1'b0;
                        end
                    end
                end else if (tick16) begin
                    d.txTicks = q.txTicks + 4'h1;
                    if (q.txTicks == `SPCS_LAST_TICK) begin
                        d.txShift = {1'b1, q.txShift[9:1]};
                        d.txBits = q.txBits + 4'h1;
                        d.pins.txd = q.txShift[1];
                        if (q.txBits == frameBits(mode) - 4'h1) begin
                            d.txState = SPCS_TX_STOP;
                            d.pins.txd = 1'b1;
                            d.ctl[`SPCS_TI] = 1'b1;
                        end
                    end
                end
            end
            SPCS_TX_STOP: begin
                if (tick16) begin
                    d.txTicks = q.txTicks + 4'h1;
                    if (q.txTicks == `SPCS_LAST_TICK) begin
                        d.txState = SPCS_TX_IDLE;
                    end
                end
            end
            default: begin
            end
        endcase

        // Receive engine
        case (q.rxState)
            SPCS_RX_IDLE: begin
                if (q.ctl[`SPCS_REN]) begin
                    if (mode == SPCS_MODE_SHIFT) begin
                        if (!q.ctl[`SPCS_RI] && q.txState == SPCS_TX_IDLE
                            && !dataWr) begin
                            d.rxState = SPCS_RX_SHIFT;
                            d.rxTicks = 4'h0;
                            d.rxBits = 4'h0;
                            d.pins.txd = 1'b0;
                        end
                    end else if (q.rxLine && !d.rxLine) begin
                        d.rxState = SPCS_RX_START;
                        d.rxTicks = 4'h0;
                    end
                end
            end
            SPCS_RX_START: begin
                // Recheck mid start bit; a glitch returns to idle
                if (tick16) begin
                    d.rxTicks = q.rxTicks + 4'h1;
                    if (q.rxTicks == `SPCS_MID_TICK) begin
                        d.rxTicks = 4'h0;
                        d.rxBits = 4'h0;
                        d.rxState = q.rxLine ? SPCS_RX_IDLE : SPCS_RX_SHIFT;
                    end
                end
            end
            SPCS_RX_SHIFT: begin
                if (mode == SPCS_MODE_SHIFT) begin
                    d.rxTicks = (q.rxTicks == `SPCS_M0_LAST) ?
                        4'h0 : q.rxTicks + 4'h1;
                    d.pins.txd = (d.rxTicks >= `SPCS_M0_HALF);
                    // Sample at bit end, behind the pin filter delay
                    if (q.rxTicks == `SPCS_M0_LAST) begin
                        d.rxShift = {q.rxLine, q.rxShift[8:1]};
                        d.rxBits = q.rxBits + 4'h1;
                        if (q.rxBits == frameBits(mode) - 4'h1) begin
                            d.rxState = SPCS_RX_IDLE;
                            d.pins.txd = 1'b1;
                            d.rxBuf = d.rxShift[8:1];
                            d.ctl[`SPCS_RI] = 1'b1;
                        end
                    end
                end else if (tick16) begin
                    d.rxTicks = q.rxTicks + 4'h1;
                    if (q.rxTicks == `SPCS_LAST_TICK) begin
                        d.rxShift = {q.rxLine, q.rxShift[8:1]};
                        d.rxBits = q.rxBits + 4'h1;
                        if (q.rxBits == frameBits(mode) - 4'h1) begin
                            d.rxState = SPCS_RX_STOP;
                        end
                    end
                end
            end
            SPCS_RX_STOP: begin
                if (tick16) begin
                    d.rxTicks = q.rxTicks + 4'h1;
                    if (q.rxTicks == `SPCS_LAST_TICK) begin
                        // Mid stop bit: decide whether the frame is kept
                        rxStopSample = 1'b1;
                        d.rxState = SPCS_RX_IDLE;
                        rxAccept = !q.ctl[`SPCS_RI];
                        if (nine && q.ctl[`SPCS_FILT] && !q.rxShift[8]) begin
                            rxAccept = 1'b0;
                        end
                        if (mode == SPCS_MODE_UART8 && q.ctl[`SPCS_FILT]
                            && !q.rxLine) begin
                            rxAccept = 1'b0;
                        end
                        if (rxAccept) begin
                            d.rxBuf = rxFrameData;
                            d.ctl[`SPCS_RB8] = rxFrameNinth;
                            d.ctl[`SPCS_RI] = 1'b1;
                        end
                    end
                end
            end
            default: begin
            end
        endcase

        // Enable cleared mid-frame drops the frame
        if (!q.ctl[`SPCS_REN] && q.rxState != SPCS_RX_IDLE) begin
            d.rxState = SPCS_RX_IDLE;
            if (mode == SPCS_MODE_SHIFT) begin
                d.pins.txd = 1'b1;
            end
        end

        // Data write restarts transmit; in mode 0 it takes the pins
        if (dataWr) begin
            d.txShift = {1'b1, nine ? q.ctl[`SPCS_TB8] : 1'b1,
                cpuReq.wrData};
            d.txBits = 4'h0;
            d.txTicks = 4'h0;
            d.pins.txd = 1'b0; // Start bit, or shift clock low in mode 0
            if (mode == SPCS_MODE_SHIFT) begin
                d.txState = SPCS_TX_SHIFT;
                d.pins.rxdOut = cpuReq.wrData[0];
                d.pins.rxdOe = 1'b1;
                d.rxState = SPCS_RX_IDLE;
            end else begin
                d.txState = SPCS_TX_START;
            end
        end
    end

    // Registered state; outputs come straight from it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= '0;
            q.ctl <= `SPCS_CTL_RST;
            q.pins <= `SPCS_PINS_RST;
            q.rxSync <= `SPCS_SYNC_RST;
            q.rxLine <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign regRdData = q.rdData;
    assign pinsOut = q.pins;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_txFlagHeld;
        q.ctl[`SPCS_TI] && !ctlWr |=> q.ctl[`SPCS_TI];
    endproperty
    a_txFlagHeld: assert property (p_txFlagHeld)
        else $error("transmit flag cleared by hardware");

    property p_rxFlagHeld;
        q.ctl[`SPCS_RI] && !ctlWr |=> q.ctl[`SPCS_RI];
    endproperty
    a_rxFlagHeld: assert property (p_rxFlagHeld)
        else $error("receive flag cleared by hardware");

    property p_rxNeedsEnable;
        !q.ctl[`SPCS_REN] && q.rxState == SPCS_RX_IDLE
            |=> q.rxState == SPCS_RX_IDLE;
    endproperty
    a_rxNeedsEnable: assert property (p_rxNeedsEnable)
        else $error("reception started while disabled");

    property p_filterNine;
        rxStopSample && nine && q.ctl[`SPCS_FILT] && !q.rxShift[8]
            && !ctlWr && !q.ctl[`SPCS_RI] |=> !q.ctl[`SPCS_RI];
    endproperty
    a_filterNine: assert property (p_filterNine)
        else $error("data frame raised receive flag under filter");

    property p_filterStop;
        rxStopSample && mode == SPCS_MODE_UART8 && q.ctl[`SPCS_FILT]
            && !q.rxLine && !ctlWr && !q.ctl[`SPCS_RI]
            |=> !q.ctl[`SPCS_RI];
    endproperty
    a_filterStop: assert property (p_filterStop)
        else $error("bad stop bit raised receive flag under filter");

    property p_rxConsistent;
        rxAccept |=> q.ctl[`SPCS_RI] && q.rxBuf == $past(rxFrameData)
            && q.ctl[`SPCS_RB8] == $past(rxFrameNinth);
    endproperty
    a_rxConsistent: assert property (p_rxConsistent)
        else $error("receive data and flag out of step");

    property p_txStartsOnWrite;
        dataWr |=> q.txState != SPCS_TX_IDLE ##1 q.txState != SPCS_TX_IDLE;
    endproperty
    a_txStartsOnWrite: assert property (p_txStartsOnWrite)
        else $error("data write did not start transmission");

    property p_ninthLoaded;
        dataWr && nine |=> q.txShift[8] == $past(q.ctl[`SPCS_TB8]);
    endproperty
    a_ninthLoaded: assert property (p_ninthLoaded)
        else $error("ninth bit not taken into the frame");

    property p_txFlagAtStop;
        $rose(q.ctl[`SPCS_TI]) && mode != SPCS_MODE_SHIFT && !$past(ctlWr)
            |-> q.txState == SPCS_TX_STOP && q.pins.txd;
    endproperty
    a_txFlagAtStop: assert property (p_txFlagAtStop)
        else $error("transmit flag not raised at stop bit");

    property p_m0ClockLow;
        mode == SPCS_MODE_SHIFT && q.txState == SPCS_TX_SHIFT
            && $fell(q.pins.txd) |-> !q.pins.txd [*3] ##1 q.pins.txd;
    endproperty
    a_m0ClockLow: assert property (p_m0ClockLow)
        else $error("mode 0 shift clock low phase wrong");

    property p_m0RxStart;
        mode == SPCS_MODE_SHIFT && q.ctl[`SPCS_REN] && !q.ctl[`SPCS_RI]
            && q.rxState == SPCS_RX_IDLE && q.txState == SPCS_TX_IDLE
            && !dataWr |=> q.rxState == SPCS_RX_SHIFT;
    endproperty
    a_m0RxStart: assert property (p_m0RxStart)
        else $error("mode 0 reception did not start");

    c_txFrame: cover property ($rose(q.ctl[`SPCS_TI]));
    c_rxAccept: cover property (rxAccept && nine);
    c_rxFiltered: cover property (rxStopSample && !rxAccept);
    c_m0Rx: cover property (mode == SPCS_MODE_SHIFT && $rose(q.ctl[`SPCS_RI]));

endmodule : spcs_port

/* File: core/spcs_cfg.svh */
// Constants of the serial port block: selects, field positions, resets,
// timing counts. Assumes clk_sys is the oscillator of the port.
`ifndef SPCS_CFG_SVH
`define SPCS_CFG_SVH

// CPU port register select
`define SPCS_SEL_CTL 1'b0
`define SPCS_SEL_DATA 1'b1

// Control/status field positions
`define SPCS_MODE_HI 7
`define SPCS_MODE_LO 6
`define SPCS_FILT 5
`define SPCS_REN 4
`define SPCS_TB8 3
`define SPCS_RB8 2
`define SPCS_TI 1
`define SPCS_RI 0

// Reset values
`define SPCS_CTL_RST 8'h00
`define SPCS_PINS_RST 3'h6
`define SPCS_SYNC_RST 3'h7

// Timing: oscillator period and divisors
`define SPCS_OSC_NS 100
`define SPCS_M0_DIV 6
`define SPCS_M0_LAST (4'(`SPCS_M0_DIV - 1))
`define SPCS_M0_HALF (4'(`SPCS_M0_DIV / 2))
`define SPCS_OVERSAMPLE 16
`define SPCS_LAST_TICK (4'(`SPCS_OVERSAMPLE - 1))
`define SPCS_MID_TICK (4'(`SPCS_OVERSAMPLE / 2 - 1))
`define SPCS_M2_DIV_SLOW 32
`define SPCS_M2_DIV_FAST 16

`endif

/* File: core/spcs_pkg.sv */
// Types shared by the serial port block: modes, states, carriers.
// Assumes spcs_cfg.svh supplies the numeric constants.
package spcs_pkg;

    typedef enum logic [1:0] {
        SPCS_MODE_SHIFT, SPCS_MODE_UART8, SPCS_MODE_UART9_FIX,
        SPCS_MODE_UART9_VAR
    } spcs_mode_t;

    typedef enum logic [1:0] {
        SPCS_TX_IDLE, SPCS_TX_START, SPCS_TX_SHIFT, SPCS_TX_STOP
    } spcs_tx_t;

    typedef enum logic [1:0] {
        SPCS_RX_IDLE, SPCS_RX_START, SPCS_RX_SHIFT, SPCS_RX_STOP
    } spcs_rx_t;

    // CPU register access request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic sel;
        logic [7:0] wrData;
    } spcs_cpu_req_t;

    // Pin drive: txd, data pin out and its enable
    typedef struct packed {
        logic txd;
        logic rxdOut;
        logic rxdOe;
    } spcs_pins_t;

    // Whole state of the port
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] rxBuf;
        logic [7:0] rdData;
        spcs_pins_t pins;
        logic [2:0] rxSync;
        logic rxLine;
        spcs_tx_t txState;
        logic [9:0] txShift;
        logic [3:0] txBits;
        logic [3:0] txTicks;
        spcs_rx_t rxState;
        logic [8:0] rxShift;
        logic [3:0] rxBits;
        logic [3:0] rxTicks;
    } spcs_state_t;

endpackage : spcs_pkg

/* File: core/spcs_rate_gen.sv */
// Oversampling tick source for the asynchronous modes.
// Assumes rateTick comes from a rate generator on clk_sys at 16x baud.
`timescale 1ns/1ps
`include "spcs_cfg.svh"
module spcs_rate_gen #(
    parameter int DIV_W = 2
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input spcs_pkg::spcs_mode_t mode,
    input wire logic smodDouble,
    input wire logic rateTick,
    output logic tick16
);
    import spcs_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic tick;
    } spcs_rate_state_t;

    spcs_rate_state_t q, d;
    logic [DIV_W-1:0] lim;

    // Divider must hold the slow mode 2 period
    if ((1 << DIV_W) < `SPCS_M2_DIV_SLOW / `SPCS_OVERSAMPLE) begin : g_divChk
        $error("DIV_W too small for the fixed rate divider");
    end

    // Fixed rate from the oscillator, variable rate from the outside tick
    always_comb begin
        d = q;
        d.tick = 1'b0;
        lim = smodDouble ?
            DIV_W'(`SPCS_M2_DIV_FAST / `SPCS_OVERSAMPLE - 1) :
            DIV_W'(`SPCS_M2_DIV_SLOW / `SPCS_OVERSAMPLE - 1);
        if (mode == SPCS_MODE_UART9_FIX) begin
            d.div = (q.div >= lim) ? '0 : q.div + 1'b1;
            d.tick = (q.div >= lim);
        end else if (mode != SPCS_MODE_SHIFT) begin
            d.div = '0;
            d.tick = rateTick;
        end else begin
            d.div = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick16 = q.tick;

endmodule : spcs_rate_gen

/* File: tb/spcs_peer.sv */
// Remote serial peer: sends frames on the data pin, captures from txd.
// Assumes the bench calls its tasks; bit times are in clk_sys cycles.
`timescale 1ns/1ps
module spcs_peer (
    input wire logic clk_sys,
    input wire logic txd,
    input wire logic rxdOut,
    input wire logic rxdOe,
    output logic rxdIn
);
    logic line = 1'b1;
    logic [7:0] m0Data = 8'h00;
    int m0Idx = 8;
    // Pin level: the port wins while it drives, else the peer line
    assign rxdIn = rxdOe ? rxdOut : line;
    // Mode 0 reception: next bit offered on each falling shift clock
    always @(negedge txd) begin
        if (m0Idx < 8) begin
            line <= m0Data[m0Idx];
            m0Idx <= m0Idx + 1;
        end
    end
    // Bounded wait on txd, counted in cycles; result is the wait length
    task automatic waitTxd(input logic v, output int n);
        n = 0;
        while (txd !== v && n < 4000) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : waitTxd
    // Async frame out: start, bits LSB first, stop bit at index nb
    task automatic sendFrame(input logic [9:0] f, input int nb, input int per);
        line <= 1'b0;
        repeat (per) @(posedge clk_sys);
        for (int i = 0; i <= nb; i++) begin
            line <= f[i];
            repeat (per) @(posedge clk_sys);
        end
        line <= 1'b1;
        repeat (per) @(posedge clk_sys);
    endtask : sendFrame
    // Async capture; bits 0 and 1 must be 1 and bit 2 must be 0
    task automatic recvFrame(input int nb, output logic [9:0] f,
                             output int per);
        int n;
        f = '1;
        waitTxd(1'b0, n);
        waitTxd(1'b1, n);
        // Start width shifts with the tick phase at the write, so the
        // bit time is taken from the two-bit high run instead
        waitTxd(1'b0, n);
        per = n / 2;
        // Bits 0 and 1 stay at 1: a wrong level there breaks the run
        repeat (per / 2) @(negedge clk_sys);
        for (int i = 2; i <= nb; i++) begin
            f[i] = txd;
            repeat (per) @(negedge clk_sys);
        end
    endtask : recvFrame
    // Mode 0 capture on each rising shift clock
    task automatic m0Recv(output logic [7:0] d, output int lowW);
        for (int i = 0; i < 8; i++) begin
            waitTxd(1'b0, lowW);
            waitTxd(1'b1, lowW);
            d[i] = rxdIn;
        end
    endtask : m0Recv
    // Preload a byte for mode 0 reception
    task automatic m0Arm(input logic [7:0] d);
        m0Data = d;
        line <= d[0];
        m0Idx = 0;
    endtask : m0Arm
endmodule : spcs_peer

/* File: tb/test_serial_port_control_status.sv */
// Self-checking bench for the serial port: register tasks and frames.
// Assumes spcs_peer stands on the pins; rateTick pulses every 2 cycles.
`timescale 1ns/1ps
`include "spcs_cfg.svh"
module test_serial_port_control_status;
    import spcs_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic rateTick = 1'b0;
    logic smodDouble = 1'b1;
    spcs_cpu_req_t cpuReq = '0;
    logic [7:0] regRdData;
    spcs_pins_t pinsOut;
    logic rxdIn;
    int fails = 0;
    int totalChecks = 0;
    logic [9:0] f;
    logic [9:0] e;
    logic [7:0] d;
    int per;
    // Transmit cases: control, rate select, data bits, cycles per bit
    logic [7:0] txCtl [4] = '{8'h40, 8'h88, 8'h88, 8'hc0};
    logic txSmod [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int txNb [4] = '{8, 9, 9, 9};
    int txPer [4] = '{32, 16, 32, 32};
    // Receive cases: control, frame, bits, period, control after, data
    logic [7:0] rxCtl [6] = '{8'h50, 8'h70, 8'hb0, 8'hf0, 8'hd0, 8'h40};
    logic [9:0] rxF [6] = '{10'h13c, 10'h0a5, 10'h2a5, 10'h3a7, 10'h242,
                            10'h199};
    int rxNb [6] = '{8, 8, 9, 9, 9, 8};
    int rxPer [6] = '{32, 32, 16, 32, 32, 32};
    logic [7:0] rxExp [6] = '{8'h55, 8'h70, 8'hb0, 8'hf5, 8'hd1, 8'h40};
    logic [7:0] rxDat [6] = '{8'h3c, 8'h3c, 8'h3c, 8'ha7, 8'h42, 8'h42};

    spcs_port dut_u (.clk_sys(clk_sys), .nrst(nrst), .cpuReq(cpuReq),
        .rateTick(rateTick), .smodDouble(smodDouble), .rxdIn(rxdIn),
        .regRdData(regRdData), .pinsOut(pinsOut));
    spcs_peer peer_u (.clk_sys(clk_sys), .txd(pinsOut.txd),
        .rxdOut(pinsOut.rxdOut), .rxdOe(pinsOut.rxdOe), .rxdIn(rxdIn));

    // Oscillator, 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // Variable-rate tick every other cycle, so async bits last 32 cycles
    always @(posedge clk_sys) begin
        rateTick <= ~rateTick;
    end

    task automatic check(input string what, input logic [9:0] seen,
                         input logic [9:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle write strobe, taken at the second edge
    task automatic wrReg(input logic sel, input logic [7:0] v);
        @(posedge clk_sys);
        cpuReq <= '{wrEn: 1'b1, rdEn: 1'b0, sel: sel, wrData: v};
        @(posedge clk_sys);
        cpuReq.wrEn <= 1'b0;
    endtask : wrReg
    // Read data is registered, so it is picked up half a cycle later
    task automatic rdReg(input logic sel, output logic [7:0] v);
        @(posedge clk_sys);
        cpuReq <= '{wrEn: 1'b0, rdEn: 1'b1, sel: sel, wrData: 8'h00};
        @(posedge clk_sys);
        cpuReq.rdEn <= 1'b0;
        @(negedge clk_sys);
        v = regRdData;
    endtask : rdReg
    task automatic checkReg(input string what, input logic sel,
                            input logic [7:0] exp);
        logic [7:0] v;
        rdReg(sel, v);
        check(what, {2'b00, v}, {2'b00, exp});
    endtask : checkReg
    task automatic tally_and_finish();
        if (fails == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the roughly 4.4k cycles the tests need
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        check("pins after reset", {7'h00, pinsOut}, 10'h006);
        checkReg("control reset", 1'b0, 8'h00);
        // Transmit in every async mode; 16 or 32 cycle bits in mode 2
        for (int k = 0; k < 4; k++) begin
            smodDouble <= txSmod[k];
            wrReg(1'b0, txCtl[k]);
            wrReg(1'b1, 8'h5b);
            peer_u.recvFrame(txNb[k], f, per);
            e = 10'h35b;
            e[8] = (txNb[k] == 9) ? txCtl[k][3] : 1'b1;
            check("tx frame", f, e);
            check("tx bit time", 10'(per), 10'(txPer[k]));
            checkReg("tx done", 1'b0, txCtl[k] | 8'h02);
        end
        repeat (200) @(posedge clk_sys);
        checkReg("tx done held", 1'b0, 8'hc2);
        smodDouble <= 1'b1;
        // Receive with and without the address filter
        for (int k = 0; k < 6; k++) begin
            wrReg(1'b0, rxCtl[k]);
            peer_u.sendFrame(rxF[k], rxNb[k], rxPer[k]);
            checkReg("rx control", 1'b0, rxExp[k]);
            checkReg("rx data", 1'b1, rxDat[k]);
        end
        // Second frame while the first is unread
        wrReg(1'b0, 8'h50);
        peer_u.sendFrame(10'h111, 8, 32);
        peer_u.sendFrame(10'h122, 8, 32);
        checkReg("overrun data", 1'b1, 8'h11);
        checkReg("rx done held", 1'b0, 8'h55);
        // Mode 0 transmit, receiver off, filter clear
        wrReg(1'b0, 8'h00);
        wrReg(1'b1, 8'h96);
        peer_u.m0Recv(d, per);
        check("m0 tx data", {2'b00, d}, 10'h096);
        check("m0 clock low", 10'(per), 10'(`SPCS_M0_DIV / 2));
        // Flag comes at the end of the last high phase, not at its start
        repeat (4) @(posedge clk_sys);
        checkReg("m0 tx done", 1'b0, 8'h02);
        // Mode 0 receive keeps the software-set ninth bit
        peer_u.m0Arm(8'hc9);
        wrReg(1'b0, 8'h14);
        repeat (70) @(posedge clk_sys);
        checkReg("m0 rx control", 1'b0, 8'h15);
        checkReg("m0 rx data", 1'b1, 8'hc9);
        tally_and_finish();
    end
endmodule : test_serial_port_control_status
